// ==== core/rmf_checker.sv ====
// dma remap fault checker: classification, blocking, recording and registers
// Contract
// - root entry not present gives reason 1h, never suppressed
// - context entry not present gives reason 2h and blocks
// - bad context programming or root pointer fetch error gives reason 3h
// - address above two to the X minus one gives reason 4h
// - write or atomic through entry without write permit gives 5h, blocked
// - read or atomic through entry without read permit gives 6h, blocked
// - zero-length reads to write-only pages raise no read fault
// - next-level table fetch error gives reason 7h
// - root table fetch error gives reason 8h
// - context table fetch error gives reason 9h, never suppressed
// - reserved bits in present root entry give reason Ah
// - reserved bits in present context entry give reason Bh
// - reserved bits in live page entry give reason Ch
// - internal errors go to platform error path, not fault reasons
// - requests beyond hardware width may also be reported separately
// - qualified faults reported only when suppress bit clear
// - every faulting request is blocked; writes dropped
// - faulting reads complete as unsupported request
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
module rmf_checker import rmf_pkg::*; (
	input wire logic clock, // 25 MHz clock
	input wire logic rst, // synchronous reset, active high
	input wire logic req_valid, // walk finished for one request
	input rmf_req_t req, // request attributes
	input rmf_walk_t walk, // walk results
	output rmf_verdict_t verdict, // verdict, one cycle after req_valid
	output rmf_record_t record, // fault record pulse
	output logic platform_error, // non-recoverable error pulse
	output logic aux_width_report, // beyond hardware width pulse
	output logic irq, // interrupt, level
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);
	typedef struct packed {
		logic check_enable;
		logic aux_enable;
		logic [2:0] int_status;
		logic [2:0] int_mask;
		logic [31:0] last_info;
		logic [63:0] last_addr;
		logic [31:0] fault_count;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		rmf_verdict_t verdict;
		rmf_record_t record;
		logic platform_error;
		logic aux_width_report;
	} rmf_state_t;

	rmf_state_t st;
	rmf_state_t next_st;

	logic width_ok;
	logic type_ok;
	logic addr_over;
	logic beyond_limit;
	logic next_fault;
	logic rsvd_fault;
	logic write_fault;
	logic read_fault;
	logic [7:0] reason;
	logic qualified;
	logic reportable;
	logic [2:0] int_set;
	logic [2:0] int_clear;
	logic do_write;
	logic [31:0] rd_value;
	logic rd_hit;
	logic wr_hit;

	rmf_width_check u_width (
		.addr(req.addr),
		.domain_width_field(walk.domain_width_field),
		.trans_type(walk.trans_type),
		.width_ok(width_ok),
		.type_ok(type_ok),
		.addr_over(addr_over),
		.beyond_limit(beyond_limit)
	);

	rmf_pte_check u_pte (
		.req(req),
		.walk(walk),
		.next_fault(next_fault),
		.rsvd_fault(rsvd_fault),
		.write_fault(write_fault),
		.read_fault(read_fault)
	);

	// walk order decides priority: the first structure that fails names the fault
	always_comb begin
		if (walk.root_fetch_err) begin
			reason = REASON_ROOT_FETCH;
		end else if (!walk.root_present) begin
			reason = REASON_ROOT_ABSENT;
		end else if (walk.root_rsvd_nz) begin
			reason = REASON_ROOT_RSVD;
		end else if (walk.ctx_fetch_err) begin
			reason = REASON_CTX_FETCH;
		end else if (!walk.ctx_present) begin
			reason = REASON_CTX_ABSENT;
		end else if (walk.ctx_rsvd_nz) begin
			reason = REASON_CTX_RSVD;
		end else if (!width_ok || !type_ok || walk.root_ptr_fetch_err) begin
			reason = REASON_CTX_PROG;
		end else if (addr_over) begin
			reason = REASON_WIDTH;
		end else if (next_fault) begin
			reason = REASON_NEXT_FETCH;
		end else if (rsvd_fault) begin
			reason = REASON_PTE_RSVD;
		end else if (write_fault) begin
			reason = REASON_WRITE_PERM;
		end else if (read_fault) begin
			reason = REASON_READ_PERM;
		end else begin
			reason = REASON_NONE;
		end
		qualified = rmf_qualified(reason);
		reportable = (reason != REASON_NONE) && (!qualified || !walk.fault_suppress_bit);
	end

	always_comb begin
		case (s_axi_araddr)
			OFS_CTRL: rd_value = {30'h0, st.aux_enable, st.check_enable};
			OFS_CAP: rd_value = {8'h0, SUPPORTED_TRANS_TYPES, 3'h0, ZERO_LENGTH_READ_SUPPORT, 3'h0,
				SUPPORTED_WIDTHS, 1'b0, MAX_GUEST_WIDTH_LIMIT};
			OFS_INT_STATUS: rd_value = {29'h0, st.int_status};
			OFS_INT_MASK: rd_value = {29'h0, st.int_mask};
			OFS_LAST_INFO: rd_value = st.last_info;
			OFS_LAST_ADDR_LO: rd_value = st.last_addr[31:0];
			OFS_LAST_ADDR_HI: rd_value = st.last_addr[63:32];
			OFS_FAULT_COUNT: rd_value = st.fault_count;
			default: rd_value = 32'h0000_0000;
		endcase
		rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= OFS_FAULT_COUNT);
		wr_hit = (st.aw_addr == OFS_CTRL) || (st.aw_addr == OFS_INT_STATUS) || (st.aw_addr == OFS_INT_MASK);
	end

	always_comb begin
		next_st = st;
		int_set = 3'h0;
		int_clear = 3'h0;
		do_write = st.aw_held && st.w_held && !st.bvalid;

		// pulses last one cycle
		next_st.verdict = '0;
		next_st.record = '0;
		next_st.platform_error = 1'b0;
		next_st.aux_width_report = 1'b0;

		if (req_valid) begin
			next_st.verdict.valid = 1'b1;
			if (!st.check_enable) begin
				next_st.verdict.reason = REASON_NONE;
			end else if (walk.internal_err) begin
				// not a remapping fault: blocked and sent down the platform error path
				next_st.verdict.blocked = 1'b1;
				next_st.verdict.drop_write = req.is_write | req.is_atomic;
				next_st.platform_error = 1'b1;
				int_set[INT_PLATFORM_BIT] = 1'b1;
			end else begin
				next_st.verdict.reason = reason;
				next_st.verdict.blocked = (reason != REASON_NONE);
				next_st.verdict.reportable = reportable;
				next_st.verdict.drop_write = (reason != REASON_NONE) && (req.is_write | req.is_atomic);
				next_st.verdict.unsupported_request = (reason != REASON_NONE) && (req.is_read | req.is_atomic);
				next_st.aux_width_report = st.aux_enable && beyond_limit;
				if (reportable) begin
					next_st.record.valid = 1'b1;
					next_st.record.reason = reason;
					next_st.record.requester = req.requester;
					next_st.record.addr = req.addr;
					next_st.last_info = '0;
					next_st.last_info[INFO_REASON_POS +: 8] = reason;
					next_st.last_info[INFO_QUAL_POS] = qualified;
					next_st.last_info[INFO_REQ_POS +: 16] = req.requester;
					next_st.last_addr = req.addr;
					next_st.fault_count = st.fault_count + 32'h0000_0001;
					int_set[INT_REPORTED_BIT] = 1'b1;
				end else if (reason != REASON_NONE) begin
					// suppressed faults still block; software only sees a sticky flag
					next_st.last_info[INFO_SUPP_POS] = 1'b1;
					int_set[INT_SUPPRESSED_BIT] = 1'b1;
				end
			end
		end

		// write channel: address and data are taken in either order
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
			case (st.aw_addr)
				OFS_CTRL: begin
					if (st.w_strb[0]) begin
						next_st.check_enable = st.w_data[CTRL_ENABLE_BIT];
						next_st.aux_enable = st.w_data[CTRL_AUX_BIT];
					end
				end
				OFS_INT_STATUS: begin
					int_clear = 3'(rmf_merge(32'h0, st.w_data, st.w_strb));
				end
				OFS_INT_MASK: begin
					next_st.int_mask = 3'(rmf_merge({29'h0, st.int_mask}, st.w_data, st.w_strb));
				end
				default: begin
					next_st.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// read channel: one read at a time, answered the cycle after the address
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_value;
			next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end

		// a new event in the cycle of its clear still lands
		next_st.int_status = (st.int_status & ~int_clear) | int_set;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
			st.check_enable <= CTRL_ENABLE_RESET;
			st.aux_enable <= CTRL_AUX_RESET;
			st.int_mask <= INT_MASK_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign verdict = st.verdict;
	assign record = st.record;
	assign platform_error = st.platform_error;
	assign aux_width_report = st.aux_width_report;
	assign irq = |(st.int_status & st.int_mask);
	assign s_axi_awready = !st.aw_held;
	assign s_axi_wready = !st.w_held;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	AST_ROOT_ABSENT: assert property (
		req_valid && st.check_enable && !walk.internal_err && !walk.root_fetch_err && !walk.root_present
		|=> verdict.reason == REASON_ROOT_ABSENT && verdict.reportable && verdict.blocked)
		else $error("root absent not reported as 1h");
	AST_CTX_ABSENT: assert property (
		verdict.valid && verdict.reason == REASON_CTX_ABSENT |-> !$past(walk.ctx_present) && verdict.blocked)
		else $error("context absent fault wrong");
	AST_CTX_PROG: assert property (
		verdict.valid && verdict.reason == REASON_CTX_PROG
		|-> !$past(width_ok) || !$past(type_ok) || $past(walk.root_ptr_fetch_err))
		else $error("context programming fault without cause");
	AST_WIDTH: assert property (
		verdict.valid && verdict.reason == REASON_WIDTH |-> $past(addr_over) && $past(width_ok))
		else $error("width fault without overflow");
	AST_WRITE_PERM: assert property (
		req_valid && st.check_enable && !walk.internal_err && reason == REASON_WRITE_PERM
		|=> verdict.blocked && verdict.drop_write && !$past(walk.pte_write))
		else $error("write permission fault not blocked");
	AST_READ_PERM: assert property (
		verdict.valid && verdict.reason == REASON_READ_PERM |-> !$past(walk.pte_read) && verdict.blocked)
		else $error("read permission fault wrong");
	AST_ZERO_READ: assert property (
		req_valid && req.is_read && !req.is_atomic && req.zero_length && walk.pte_write && ZERO_LENGTH_READ_SUPPORT
		|=> verdict.reason != REASON_READ_PERM)
		else $error("zero-length read raised read fault");
	AST_PLATFORM: assert property (
		req_valid && st.check_enable && walk.internal_err
		|=> platform_error && verdict.blocked && verdict.reason == REASON_NONE && !record.valid)
		else $error("internal error classified as fault");
	AST_SUPPRESS: assert property (
		verdict.valid && verdict.reason != REASON_NONE && !verdict.reportable
		|-> rmf_qualified(verdict.reason) && $past(walk.fault_suppress_bit))
		else $error("fault suppressed wrongly");
	AST_BLOCK: assert property (
		verdict.valid && verdict.reason != REASON_NONE |-> verdict.blocked)
		else $error("fault not blocked");
	AST_UR: assert property (
		req_valid && st.check_enable && !walk.internal_err && req.is_read && reason != REASON_NONE
		|=> verdict.unsupported_request)
		else $error("faulting read not unsupported request");
	AST_RECORD: assert property (
		verdict.reportable |-> record.valid && record.reason == verdict.reason && record.addr == $past(req.addr))
		else $error("record missing for reportable fault");
	AST_IRQ: assert property (
		record.valid && st.int_mask[INT_REPORTED_BIT] |-> irq)
		else $error("interrupt not raised");
	AST_ROOT_FETCH: assert property (
		verdict.reason == REASON_ROOT_FETCH |-> $past(walk.root_fetch_err) && verdict.reportable)
		else $error("root fetch fault wrong");
	AST_CTX_FETCH: assert property (
		verdict.reason == REASON_CTX_FETCH |-> $past(walk.ctx_fetch_err) && verdict.reportable)
		else $error("context fetch fault wrong");
	AST_ROOT_RSVD: assert property (
		verdict.reason == REASON_ROOT_RSVD |-> $past(walk.root_rsvd_nz) && $past(walk.root_present))
		else $error("root reserved fault wrong");
	AST_CTX_RSVD: assert property (
		verdict.reason == REASON_CTX_RSVD |-> $past(walk.ctx_rsvd_nz) && $past(walk.ctx_present))
		else $error("context reserved fault wrong");
	AST_PTE_RSVD: assert property (
		verdict.reason == REASON_PTE_RSVD |-> $past(walk.pte_rsvd_nz) && ($past(walk.pte_read) || $past(walk.pte_write)))
		else $error("page reserved fault wrong");
	AST_NEXT_FETCH: assert property (
		verdict.reason == REASON_NEXT_FETCH |-> $past(walk.pte_next_fetch_err))
		else $error("next fetch fault wrong");
endmodule

// ==== core/rmf_pkg.sv ====
// shared types and constants of the dma remap fault checker
package rmf_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CAP = 8'h04;
	localparam logic [7:0] OFS_INT_STATUS = 8'h08;
	localparam logic [7:0] OFS_INT_MASK = 8'h0C;
	localparam logic [7:0] OFS_LAST_INFO = 8'h10;
	localparam logic [7:0] OFS_LAST_ADDR_LO = 8'h14;
	localparam logic [7:0] OFS_LAST_ADDR_HI = 8'h18;
	localparam logic [7:0] OFS_FAULT_COUNT = 8'h1C;

	// control fields and reset values
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_AUX_BIT = 1;
	localparam logic CTRL_ENABLE_RESET = 1'b1;
	localparam logic CTRL_AUX_RESET = 1'b0;
	localparam logic [2:0] INT_MASK_RESET = 3'h0;

	// interrupt status bit positions
	localparam int INT_REPORTED_BIT = 0;
	localparam int INT_SUPPRESSED_BIT = 1;
	localparam int INT_PLATFORM_BIT = 2;

	// capability layout and values
	localparam logic [6:0] MAX_GUEST_WIDTH_LIMIT = 7'h30;
	localparam logic [4:0] SUPPORTED_WIDTHS = 5'h06;
	localparam logic [3:0] SUPPORTED_TRANS_TYPES = 4'h5;
	localparam logic ZERO_LENGTH_READ_SUPPORT = 1'b1;
	localparam int CAP_WIDTH_POS = 0;
	localparam int CAP_SGAW_POS = 8;
	localparam int CAP_ZERO_READ_POS = 16;
	localparam int CAP_TT_POS = 20;

	// last fault info layout
	localparam int INFO_REASON_POS = 0;
	localparam int INFO_QUAL_POS = 8;
	localparam int INFO_SUPP_POS = 9;
	localparam int INFO_REQ_POS = 16;

	// domain width: guest width = base + step * field
	localparam logic [6:0] AGAW_BASE = 7'h1E;
	localparam logic [6:0] AGAW_STEP = 7'h09;

	// fault reasons
	localparam logic [7:0] REASON_NONE = 8'h00;
	localparam logic [7:0] REASON_ROOT_ABSENT = 8'h01;
	localparam logic [7:0] REASON_CTX_ABSENT = 8'h02;
	localparam logic [7:0] REASON_CTX_PROG = 8'h03;
	localparam logic [7:0] REASON_WIDTH = 8'h04;
	localparam logic [7:0] REASON_WRITE_PERM = 8'h05;
	localparam logic [7:0] REASON_READ_PERM = 8'h06;
	localparam logic [7:0] REASON_NEXT_FETCH = 8'h07;
	localparam logic [7:0] REASON_ROOT_FETCH = 8'h08;
	localparam logic [7:0] REASON_CTX_FETCH = 8'h09;
	localparam logic [7:0] REASON_ROOT_RSVD = 8'h0A;
	localparam logic [7:0] REASON_CTX_RSVD = 8'h0B;
	localparam logic [7:0] REASON_PTE_RSVD = 8'h0C;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [63:0] addr;
		logic [15:0] requester;
		logic is_read;
		logic is_write;
		logic is_atomic;
		logic zero_length;
	} rmf_req_t;

	typedef struct packed {
		logic internal_err;
		logic root_fetch_err;
		logic root_present;
		logic root_rsvd_nz;
		logic ctx_fetch_err;
		logic ctx_present;
		logic ctx_rsvd_nz;
		logic [2:0] domain_width_field;
		logic [1:0] trans_type;
		logic root_ptr_fetch_err;
		logic fault_suppress_bit;
		logic pte_read;
		logic pte_write;
		logic pte_rsvd_nz;
		logic pte_next_fetch_err;
	} rmf_walk_t;

	typedef struct packed {
		logic valid;
		logic blocked;
		logic [7:0] reason;
		logic reportable;
		logic unsupported_request;
		logic drop_write;
	} rmf_verdict_t;

	typedef struct packed {
		logic valid;
		logic [7:0] reason;
		logic [15:0] requester;
		logic [63:0] addr;
	} rmf_record_t;

	// faults before a context entry is known cannot be suppressed
	function automatic logic rmf_qualified(input logic [7:0] reason);
		case (reason)
			REASON_ROOT_ABSENT, REASON_ROOT_FETCH, REASON_CTX_FETCH, REASON_ROOT_RSVD: rmf_qualified = 1'b0;
			default: rmf_qualified = 1'b1;
		endcase
	endfunction

	function automatic logic [31:0] rmf_merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			rmf_merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

endpackage

// ==== core/rmf_width_check.sv ====
// domain width and address range checks
module rmf_width_check import rmf_pkg::*; (
	input wire logic [63:0] addr, // request address
	input wire logic [2:0] domain_width_field, // context width code
	input wire logic [1:0] trans_type, // context translation type
	output logic width_ok, // width code supported
	output logic type_ok, // translation type supported
	output logic addr_over, // beyond effective width
	output logic beyond_limit // beyond the hardware limit alone
);
	logic [6:0] agaw;
	logic [6:0] x;

	always_comb begin
		agaw = AGAW_BASE + 7'(AGAW_STEP * 7'(domain_width_field));
		width_ok = (domain_width_field < 3'h5) && SUPPORTED_WIDTHS[domain_width_field];
		type_ok = SUPPORTED_TRANS_TYPES[trans_type];
		x = (agaw < MAX_GUEST_WIDTH_LIMIT) ? agaw : MAX_GUEST_WIDTH_LIMIT;
		addr_over = |(addr >> x);
		beyond_limit = |(addr >> MAX_GUEST_WIDTH_LIMIT);
	end
endmodule

// ==== core/rmf_pte_check.sv ====
// page-table entry permission and reserved field checks
module rmf_pte_check import rmf_pkg::*; (
	input rmf_req_t req, // request attributes
	input rmf_walk_t walk, // walk results
	output logic next_fault, // next-level fetch error
	output logic rsvd_fault, // reserved bits in a live entry
	output logic write_fault, // write permission missing
	output logic read_fault // read permission missing
);
	logic zero_read_exempt;

	always_comb begin
		next_fault = walk.pte_next_fetch_err;
		rsvd_fault = (walk.pte_read | walk.pte_write) & walk.pte_rsvd_nz;
		write_fault = (req.is_write | req.is_atomic) & ~walk.pte_write;
		// flushes to write-only pages pass when the capability is set
		zero_read_exempt = ZERO_LENGTH_READ_SUPPORT & req.is_read & ~req.is_atomic & req.zero_length
			& walk.pte_write;
		read_fault = (req.is_read | req.is_atomic) & ~walk.pte_read & ~zero_read_exempt;
	end
endmodule

// ==== verification/rmf_dma_src.sv ====
// model of the io devices that hand finished request walks to the fault checker
module rmf_dma_src import rmf_pkg::*; (
	input wire logic clock, // system clock
	output logic req_valid, // request pulse
	output rmf_req_t req, // request attributes
	output rmf_walk_t walk // walk results
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_valid = 1'b0;
		req = '0;
		walk = '0;
	end
	// fields are inverted once the pulse ends so that a stale value is never mistaken for a live one
	task automatic issue(input rmf_req_t r, input rmf_walk_t w);
		@(posedge clock);
		req_valid <= 1'b1;
		req <= r;
		walk <= w;
		@(posedge clock);
		req_valid <= 1'b0;
		req <= ~r;
		walk <= ~w;
	endtask
endmodule

// ==== verification/dma_remap_fault_checker_tb.sv ====
// self-checking bench of the dma remap fault checker
module dma_remap_fault_checker_tb import rmf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic req_valid;
	rmf_req_t req;
	rmf_walk_t walk;
	rmf_verdict_t verdict;
	rmf_record_t record;
	logic platform_error;
	logic aux_width_report;
	logic irq;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	int fail_count = 0;
	int samples_checked = 0;
	rmf_verdict_t v;
	rmf_record_t rc;
	logic pe;
	logic aux;

	always #20 clock = ~clock;

	rmf_dma_src i_rmf_dma_src (.clock, .req_valid, .req, .walk);
	rmf_checker i_rmf_checker (
		.clock, .rst, .req_valid, .req, .walk, .verdict, .record, .platform_error, .aux_width_report, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_go;
		logic w_go;
		logic b_go;
		logic [1:0] br;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clock);
			aw_go = s_axi_awvalid && s_axi_awready;
			w_go = s_axi_wvalid && s_axi_wready;
			b_go = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge clock);
			if (aw_go) s_axi_awvalid <= 1'b0;
			if (w_go) s_axi_wvalid <= 1'b0;
			if (b_go) break;
		end
		s_axi_bready <= 1'b0;
		chk("bvalid", 1'b1, b_go);
		chk("bresp", er, br);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic ar_go;
		logic r_go;
		logic [1:0] rr;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clock);
			ar_go = s_axi_arvalid && s_axi_arready;
			r_go = s_axi_rvalid;
			rr = s_axi_rresp;
			d = s_axi_rdata;
			@(posedge clock);
			if (ar_go) s_axi_arvalid <= 1'b0;
			if (r_go) break;
		end
		s_axi_rready <= 1'b0;
		chk("rvalid", 1'b1, r_go);
		chk("rresp", er, rr);
	endtask

	// a fully valid walk at 48 bits that translates cleanly
	function automatic rmf_walk_t gw();
		gw = '0;
		gw.root_present = 1'b1;
		gw.ctx_present = 1'b1;
		gw.domain_width_field = 3'h2;
		gw.pte_read = 1'b1;
		gw.pte_write = 1'b1;
	endfunction

	function automatic rmf_req_t gr(input logic rd, input logic wr);
		gr = '0;
		gr.addr = 64'h0000_0000_0000_1000;
		gr.requester = 16'hA5C3;
		gr.is_read = rd;
		gr.is_write = wr;
	endfunction

	task automatic run(input rmf_req_t r, input rmf_walk_t w, input logic [7:0] er, input logic erep,
			input logic eblk);
		i_rmf_dma_src.issue(r, w);
		#1;
		v = verdict;
		rc = record;
		pe = platform_error;
		aux = aux_width_report;
		chk("valid", 1'b1, v.valid);
		chk("reason", er, v.reason);
		chk("reportable", erep, v.reportable);
		chk("blocked", eblk, v.blocked);
		chk("record", erep, rc.valid);
	endtask

	task automatic t_regs();
		rmf_req_t r;
		rmf_walk_t w;
		logic [31:0] d;
		axi_rd(OFS_CTRL, d, RESP_OKAY);
		chk("ctrl", 32'h0000_0001, d);
		axi_rd(OFS_CAP, d, RESP_OKAY);
		chk("cap", 32'h0051_0630, d);
		axi_wr(OFS_CAP, 32'h0000_0000, RESP_SLVERR);
		axi_rd(8'h20, d, RESP_SLVERR);
		axi_wr(8'h20, 32'h0000_0001, RESP_SLVERR);
		axi_wr(OFS_INT_MASK, 32'h0000_0001, RESP_OKAY);
		r = gr(1'b1, 1'b0);
		r.requester = 16'h3C5A;
		r.addr = 64'h0000_0012_3456_7000;
		w = gw();
		w.ctx_present = 1'b0;
		run(r, w, REASON_CTX_ABSENT, 1'b1, 1'b1);
		chk("rec_reason", REASON_CTX_ABSENT, rc.reason);
		chk("rec_req", 16'h3C5A, rc.requester);
		chk("rec_addr", r.addr, rc.addr);
		axi_rd(OFS_LAST_INFO, d, RESP_OKAY);
		chk("info", 32'h3C5A_0102, d);
		axi_rd(OFS_LAST_ADDR_HI, d, RESP_OKAY);
		chk("addr_hi", 32'h0000_0012, d);
		chk("irq", 1'b1, irq);
		axi_wr(OFS_INT_STATUS, 32'h0000_0001, RESP_OKAY);
		chk("irq_clr", 1'b0, irq);
		w.fault_suppress_bit = 1'b1;
		run(r, w, REASON_CTX_ABSENT, 1'b0, 1'b1);
		axi_rd(OFS_INT_STATUS, d, RESP_OKAY);
		chk("status", 32'h0000_0002, d);
		chk("irq_mask", 1'b0, irq);
		axi_rd(OFS_FAULT_COUNT, d, RESP_OKAY);
		chk("count", 32'h0000_0001, d);
	endtask

	// faults found before any context entry is known ignore the suppress bit
	task automatic t_root();
		rmf_walk_t w;
		w = gw();
		w.fault_suppress_bit = 1'b1;
		w.root_present = 1'b0;
		run(gr(1'b1, 1'b0), w, REASON_ROOT_ABSENT, 1'b1, 1'b1);
		w.root_fetch_err = 1'b1;
		run(gr(1'b1, 1'b0), w, REASON_ROOT_FETCH, 1'b1, 1'b1);
		w = gw();
		w.fault_suppress_bit = 1'b1;
		w.ctx_fetch_err = 1'b1;
		run(gr(1'b0, 1'b1), w, REASON_CTX_FETCH, 1'b1, 1'b1);
		w.ctx_fetch_err = 1'b0;
		w.root_rsvd_nz = 1'b1;
		run(gr(1'b0, 1'b1), w, REASON_ROOT_RSVD, 1'b1, 1'b1);
	endtask

	task automatic t_ctx();
		rmf_walk_t w;
		w = gw();
		w.fault_suppress_bit = 1'b1;
		w.ctx_rsvd_nz = 1'b1;
		run(gr(1'b1, 1'b0), w, REASON_CTX_RSVD, 1'b0, 1'b1);
		w = gw();
		w.domain_width_field = 3'h0;
		run(gr(1'b1, 1'b0), w, REASON_CTX_PROG, 1'b1, 1'b1);
		w = gw();
		w.trans_type = 2'h1;
		run(gr(1'b1, 1'b0), w, REASON_CTX_PROG, 1'b1, 1'b1);
		w = gw();
		w.root_ptr_fetch_err = 1'b1;
		run(gr(1'b1, 1'b0), w, REASON_CTX_PROG, 1'b1, 1'b1);
	endtask

	task automatic t_width();
		rmf_req_t r;
		rmf_walk_t w;
		w = gw();
		w.domain_width_field = 3'h1;
		r = gr(1'b0, 1'b1);
		r.addr = 64'h0000_0080_0000_0000;
		run(r, w, REASON_WIDTH, 1'b1, 1'b1);
		chk("drop_write", 1'b1, v.drop_write);
		r.addr = 64'h0000_007F_FFFF_FFFF;
		run(r, w, REASON_NONE, 1'b0, 1'b0);
		axi_wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
		w = gw();
		r.addr = 64'h0001_0000_0000_0000;
		run(r, w, REASON_WIDTH, 1'b1, 1'b1);
		chk("aux", 1'b1, aux);
		r.addr = 64'h0000_FFFF_FFFF_FFFF;
		run(r, w, REASON_NONE, 1'b0, 1'b0);
		chk("aux_ok", 1'b0, aux);
		axi_wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
		w.root_present = 1'b0;
		run(r, w, REASON_NONE, 1'b0, 1'b0);
		axi_wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
	endtask

	task automatic t_pte();
		rmf_req_t r;
		rmf_walk_t w;
		w = gw();
		w.pte_write = 1'b0;
		run(gr(1'b0, 1'b1), w, REASON_WRITE_PERM, 1'b1, 1'b1);
		chk("ur_write", 1'b0, v.unsupported_request);
		r = gr(1'b0, 1'b0);
		r.is_atomic = 1'b1;
		run(r, w, REASON_WRITE_PERM, 1'b1, 1'b1);
		w = gw();
		w.pte_read = 1'b0;
		run(gr(1'b1, 1'b0), w, REASON_READ_PERM, 1'b1, 1'b1);
		chk("ur_read", 1'b1, v.unsupported_request);
		r.zero_length = 1'b1;
		run(r, w, REASON_READ_PERM, 1'b1, 1'b1);
		r = gr(1'b1, 1'b0);
		r.zero_length = 1'b1;
		run(r, w, REASON_NONE, 1'b0, 1'b0);
		w = gw();
		w.pte_next_fetch_err = 1'b1;
		run(gr(1'b1, 1'b0), w, REASON_NEXT_FETCH, 1'b1, 1'b1);
		w = gw();
		w.pte_write = 1'b0;
		w.pte_rsvd_nz = 1'b1;
		run(gr(1'b1, 1'b0), w, REASON_PTE_RSVD, 1'b1, 1'b1);
	endtask

	task automatic t_internal();
		rmf_walk_t w;
		logic [31:0] d;
		w = gw();
		w.internal_err = 1'b1;
		w.root_present = 1'b0;
		run(gr(1'b1, 1'b0), w, REASON_NONE, 1'b0, 1'b1);
		chk("platform", 1'b1, pe);
		axi_rd(OFS_INT_STATUS, d, RESP_OKAY);
		chk("status_all", 32'h0000_0007, d);
	endtask

	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_root();
		t_ctx();
		t_width();
		t_pte();
		t_internal();
		test_done();
	end

	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		test_done();
	end
endmodule
